// file: inc/ufif_defs.svh
// Register offsets, field positions, reset values and masks of the USB event flag block
`ifndef UFIF_DEFS_SVH
`define UFIF_DEFS_SVH

`define UFIF_ADDR_W 8
`define UFIF_DATA_W 32

// Register byte offsets
`define UFIF_OFS_FLAGS_0 8'h00
`define UFIF_OFS_FLAGS_1 8'h04
`define UFIF_OFS_FLAGS_2 8'h08
`define UFIF_OFS_SELECT_0 8'h0c
`define UFIF_OFS_SELECT_1 8'h10
`define UFIF_OFS_SELECT_2 8'h14
`define UFIF_OFS_ENABLE_0 8'h18
`define UFIF_OFS_ENABLE_1 8'h1c
`define UFIF_OFS_ENABLE_2 8'h20
`define UFIF_OFS_CONTROL 8'h24

// First flag register fields
`define UFIF_B_BUS_RESET 7
`define UFIF_B_BULK_OUT_FULL 6
`define UFIF_B_BULK_IN_TR 5
`define UFIF_B_BULK_IN_EMPTY 4
`define UFIF_B_SETUP_RX 3
`define UFIF_B_CTRL_OUT_DONE 2
`define UFIF_B_CTRL_IN_TR 1
`define UFIF_B_CTRL_IN_DONE 0
// Second flag register fields
`define UFIF_B_CABLE_LEVEL 3
`define UFIF_B_INTR_IN_TR 2
`define UFIF_B_INTR_IN_DONE 1
`define UFIF_B_CONN_CHANGE 0
// Third flag register fields
`define UFIF_B_SUSP_STATE 5
`define UFIF_B_SUSP_CHANGE 4
`define UFIF_B_EPINFO_DONE 3
`define UFIF_B_SET_CONFIG 1
`define UFIF_B_SET_ALT 0
// Control register fields
`define UFIF_B_POWER_SELF 0
`define UFIF_B_PULLUP_EN 1

// Flag vector is {flags_2, flags_1, flags_0}
`define UFIF_FLAG_RST 24'h000010
`define UFIF_CLR_MASK 24'h1b07af
`define UFIF_STAT_MASK 24'h200850
`define UFIF_IRQ_MASK 24'h1b07ff
`define UFIF_SEL_RST 24'h1f0700
`define UFIF_SEL_ONES 24'h040000
`define UFIF_EN_RST 24'h000000
`define UFIF_CTRL_RST 8'h00
`define UFIF_CTRL_MASK 8'h03

`endif

// file: inc/ufif_pkg.sv
// Types shared by the USB event flag block
package ufif_pkg;
	typedef enum logic [1:0] {
		UFIF_OKAY = 2'h0,
		UFIF_SLVERR = 2'h2
	} ufif_resp_t;
	typedef logic [23:0] ufif_flags_t;
	typedef logic [7:0] ufif_byte_t;
endpackage : ufif_pkg

// file: rtl/ufif_axil.sv
// AXI4-Lite slave front end of the USB event flag block
`timescale 1ns/1ps
`default_nettype none
`include "ufif_defs.svh"
module ufif_axil (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Write address and data
	input wire logic [`UFIF_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [`UFIF_DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// Write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read address and data
	input wire logic [`UFIF_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [`UFIF_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register file side
	output logic wr_en,
	output logic [`UFIF_ADDR_W-1:0] wr_addr,
	output logic [7:0] wr_data,
	input wire logic wr_ok,
	output logic [`UFIF_ADDR_W-1:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic rd_ok
);
	logic aw_rdy_r;
	logic w_rdy_r;
	logic [`UFIF_ADDR_W-1:0] aw_addr_r;
	logic [7:0] w_data_r;
	logic w_lane_r;
	logic [1:0] bresp_r;
	logic bvalid_r;
	logic ar_rdy_r;
	logic [`UFIF_DATA_W-1:0] rdata_r;
	logic [1:0] rresp_r;
	logic rvalid_r;
	wire aw_take = awvalid & aw_rdy_r;
	wire w_take = wvalid & w_rdy_r;
	wire wr_go = ~aw_rdy_r & ~w_rdy_r & ~bvalid_r;
	wire b_done = bvalid_r & bready;
	wire ar_take = arvalid & ar_rdy_r;
	wire r_done = rvalid_r & rready;

	// Only byte lane 0 carries register bits; a write without it stores nothing
	assign wr_en = wr_go & w_lane_r;
	assign wr_addr = aw_addr_r;
	assign wr_data = w_data_r;
	assign rd_addr = araddr;
	assign awready = aw_rdy_r;
	assign wready = w_rdy_r;
	assign bresp = bresp_r;
	assign bvalid = bvalid_r;
	assign arready = ar_rdy_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign rvalid = rvalid_r;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			aw_rdy_r <= 1'b1;
			aw_addr_r <= '0;
		end else if (aw_take) begin
			aw_rdy_r <= 1'b0;
			aw_addr_r <= awaddr;
		end else if (b_done) begin
			aw_rdy_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			w_rdy_r <= 1'b1;
			w_data_r <= '0;
			w_lane_r <= 1'b0;
		end else if (w_take) begin
			w_rdy_r <= 1'b0;
			w_data_r <= wdata[7:0];
			w_lane_r <= wstrb[0];
		end else if (b_done) begin
			w_rdy_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bvalid_r <= 1'b0;
			bresp_r <= ufif_pkg::UFIF_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_ok ? ufif_pkg::UFIF_OKAY : ufif_pkg::UFIF_SLVERR;
		end else if (b_done) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ar_rdy_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= ufif_pkg::UFIF_OKAY;
		end else if (ar_take) begin
			ar_rdy_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= {24'h000000, rd_data};
			rresp_r <= rd_ok ? ufif_pkg::UFIF_OKAY : ufif_pkg::UFIF_SLVERR;
		end else if (r_done) begin
			ar_rdy_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end
endmodule : ufif_axil
`default_nettype wire

// file: rtl/ufif_top.sv
// Event flag, enable and vector select logic of a full-speed USB function controller
// Notes on behaviour
// - Events set flags; enabled set flags interrupt
// - Write zero clears bit, one leaves it
// - Bus reset sets flag bit seven
// - Bulk-out full follows received packet, read-only
// - Bulk-in IN token without data sets request
// - IN endpoint without data answers NACK
// - Bulk-in empty shows free buffer, resets one
// - Acknowledged firmware setup sets bit three
// - Acknowledged control-out data sets bit two
// - Control-in IN token without data sets request
// - Acknowledged control-in data sets bit zero
// - Cable level mirrored, gated by pull-up, silent
// - Interrupt-in IN token without data sets request
// - Acknowledged interrupt-in data sets done flag
// - Cable attach or detach sets change flag
// - Suspend state bit read-only, never interrupts
// - Suspend transitions set flag, drive resume
// - Endpoint load done flagged; operation waits
// - Reserved flag bits read zero
// - Power mode bit selects self or bus
// - Select bit routes to vector A or B
// - Set configuration and set interface flagged
`timescale 1ns/1ps
`default_nettype none
`include "ufif_defs.svh"
module ufif_top (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_B,
	// AXI4-Lite write channels
	input wire logic [`UFIF_ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [`UFIF_DATA_W-1:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read channels
	input wire logic [`UFIF_ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [`UFIF_DATA_W-1:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Bus events from the protocol engine, one-cycle pulses
	input wire logic BUS_RESET_DET,
	input wire logic SETUP_ACK_DONE,
	input wire logic CTRL_OUT_ACK_DONE,
	input wire logic CTRL_IN_TOKEN,
	input wire logic CTRL_IN_ACK_DONE,
	input wire logic BULK_OUT_RX_DONE,
	input wire logic BULK_IN_TOKEN,
	input wire logic INTR_IN_TOKEN,
	input wire logic INTR_IN_ACK_DONE,
	input wire logic EPINFO_LOAD_END,
	input wire logic SET_CONFIG_SEEN,
	input wire logic SET_ALT_SEEN,
	// Levels from the endpoint buffers and the bus
	input wire logic CTRL_IN_TX_VALID,
	input wire logic BULK_OUT_DATA_VALID,
	input wire logic BULK_IN_TX_VALID,
	input wire logic BULK_IN_BUF_FREE,
	input wire logic INTR_IN_TX_VALID,
	input wire logic BUS_SUSPENDED,
	input wire logic VBUS,
	// Interrupt vectors and resume
	output logic USB_VECTOR_A,
	output logic USB_VECTOR_B,
	output logic RESUME_OUT,
	// Handshake control towards the protocol engine
	output logic CTRL_IN_NACK,
	output logic BULK_IN_NACK,
	output logic INTR_IN_NACK,
	output logic USB_RUN,
	// Power and pull-up control
	output logic SELF_POWERED,
	output logic PULLUP_ON
);
	logic wr_en;
	logic [`UFIF_ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;
	logic [`UFIF_ADDR_W-1:0] rd_addr;
	logic [7:0] rd_data;
	ufif_pkg::ufif_flags_t flags_r;
	ufif_pkg::ufif_flags_t flags_nxt;
	ufif_pkg::ufif_flags_t sel_r;
	ufif_pkg::ufif_flags_t en_r;
	logic [7:0] ctrl_r;
	logic vbus_prev_r;
	logic susp_prev_r;
	logic vec_a_r;
	logic vec_b_r;
	logic resume_r;
	logic ctrl_nack_r;
	logic bulk_nack_r;
	logic intr_nack_r;
	logic run_r;
	logic self_r;
	logic pullup_r;

	// Decode of the write address held by the slave and of the live read address; a mapped address is any of the ten words
	wire wr_hit = (wr_addr[1:0] == 2'h0) & (wr_addr <= `UFIF_OFS_CONTROL);
	wire rd_hit = (rd_addr[1:0] == 2'h0) & (rd_addr <= `UFIF_OFS_CONTROL);

	ufif_axil u_ufif_axil (
		.clk(MCLK),
		.rst_b(RST_B),
		.awaddr(AWADDR),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.wvalid(WVALID),
		.wready(WREADY),
		.bresp(BRESP),
		.bvalid(BVALID),
		.bready(BREADY),
		.araddr(ARADDR),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.rvalid(RVALID),
		.rready(RREADY),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_ok(wr_hit),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_hit)
	);

	// Write decode
	wire wr_f0 = wr_en & (wr_addr == `UFIF_OFS_FLAGS_0);
	wire wr_f1 = wr_en & (wr_addr == `UFIF_OFS_FLAGS_1);
	wire wr_f2 = wr_en & (wr_addr == `UFIF_OFS_FLAGS_2);
	wire wr_s0 = wr_en & (wr_addr == `UFIF_OFS_SELECT_0);
	wire wr_s1 = wr_en & (wr_addr == `UFIF_OFS_SELECT_1);
	wire wr_s2 = wr_en & (wr_addr == `UFIF_OFS_SELECT_2);
	wire wr_e0 = wr_en & (wr_addr == `UFIF_OFS_ENABLE_0);
	wire wr_e1 = wr_en & (wr_addr == `UFIF_OFS_ENABLE_1);
	wire wr_e2 = wr_en & (wr_addr == `UFIF_OFS_ENABLE_2);
	wire wr_ct = wr_en & (wr_addr == `UFIF_OFS_CONTROL);
	wire [2:0] wr_sel = {wr_s2, wr_s1, wr_s0};
	wire [2:0] wr_ena = {wr_e2, wr_e1, wr_e0};

	// Read decode
	wire rd_f0 = (rd_addr == `UFIF_OFS_FLAGS_0);
	wire rd_f1 = (rd_addr == `UFIF_OFS_FLAGS_1);
	wire rd_f2 = (rd_addr == `UFIF_OFS_FLAGS_2);
	wire rd_s0 = (rd_addr == `UFIF_OFS_SELECT_0);
	wire rd_s1 = (rd_addr == `UFIF_OFS_SELECT_1);
	wire rd_s2 = (rd_addr == `UFIF_OFS_SELECT_2);
	wire rd_e0 = (rd_addr == `UFIF_OFS_ENABLE_0);
	wire rd_e1 = (rd_addr == `UFIF_OFS_ENABLE_1);
	wire rd_e2 = (rd_addr == `UFIF_OFS_ENABLE_2);
	wire rd_ct = (rd_addr == `UFIF_OFS_CONTROL);

	// Zero bits of a flag write clear, one bits leave the flag alone
	wire [23:0] clr_req = {wr_f2 ? ~wr_data : 8'h00, wr_f1 ? ~wr_data : 8'h00, wr_f0 ? ~wr_data : 8'h00};

	// Inputs are synchronous to MCLK, so a single register gives the edge
	wire vbus_edge = VBUS ^ vbus_prev_r;
	wire susp_edge = BUS_SUSPENDED ^ susp_prev_r;
	wire bulk_in_tr = BULK_IN_TOKEN & ~BULK_IN_TX_VALID;
	wire ctrl_in_tr = CTRL_IN_TOKEN & ~CTRL_IN_TX_VALID;
	wire intr_in_tr = INTR_IN_TOKEN & ~INTR_IN_TX_VALID;

	// Set pulses of the event flags
	wire [7:0] set_0 = {
		BUS_RESET_DET,
		1'b0,
		bulk_in_tr,
		1'b0,
		SETUP_ACK_DONE,
		CTRL_OUT_ACK_DONE,
		ctrl_in_tr,
		CTRL_IN_ACK_DONE
	};
	wire [7:0] set_1 = {
		5'h00,
		intr_in_tr,
		INTR_IN_ACK_DONE,
		vbus_edge
	};
	wire [7:0] set_2 = {
		3'h0,
		susp_edge,
		EPINFO_LOAD_END,
		1'b0,
		SET_CONFIG_SEEN,
		SET_ALT_SEEN
	};
	wire [23:0] set_req = {set_2, set_1, set_0};

	// Status bits follow their levels every cycle and ignore writes
	wire [7:0] stat_0 = {
		1'b0,
		BULK_OUT_RX_DONE | BULK_OUT_DATA_VALID,
		1'b0,
		BULK_IN_BUF_FREE,
		4'h0
	};
	wire [7:0] stat_1 = {4'h0, VBUS & pullup_r, 3'h0};
	wire [7:0] stat_2 = {2'h0, BUS_SUSPENDED, 5'h00};
	wire [23:0] stat_lvl = {stat_2, stat_1, stat_0};

	localparam logic [23:0] CLR_MASK = `UFIF_CLR_MASK;
	localparam logic [23:0] STAT_MASK = `UFIF_STAT_MASK;
	localparam logic [23:0] FLAG_RST = `UFIF_FLAG_RST;
	localparam logic [23:0] IRQ_MASK = `UFIF_IRQ_MASK;
	localparam logic [23:0] SEL_RST = `UFIF_SEL_RST;
	localparam logic [23:0] SEL_ONES = `UFIF_SEL_ONES;
	localparam logic [23:0] EN_RST = `UFIF_EN_RST;

	// One flag per bit; the kind of bit is fixed by the masks
	genvar gi;
	generate
		for (gi = 0; gi < 24; gi++) begin : g_flag
			if (CLR_MASK[gi]) begin : g_evt
				// Set wins so an event in the clearing cycle is not lost
				assign flags_nxt[gi] = set_req[gi] | (flags_r[gi] & ~clr_req[gi]);
			end else if (STAT_MASK[gi]) begin : g_stat
				assign flags_nxt[gi] = stat_lvl[gi];
			end else begin : g_rsvd
				assign flags_nxt[gi] = 1'b0;
			end
			always_ff @(posedge MCLK) begin
				if (!RST_B) begin
					flags_r[gi] <= FLAG_RST[gi];
				end else begin
					flags_r[gi] <= flags_nxt[gi];
				end
			end
		end
	endgenerate

	// Select and enable registers, one byte per flag register
	genvar gk;
	generate
		for (gk = 0; gk < 3; gk++) begin : g_byte
			always_ff @(posedge MCLK) begin
				if (!RST_B) begin
					sel_r[gk*8 +: 8] <= SEL_RST[gk*8 +: 8];
					en_r[gk*8 +: 8] <= EN_RST[gk*8 +: 8];
				end else begin
					if (wr_sel[gk]) begin
						sel_r[gk*8 +: 8] <= (wr_data & IRQ_MASK[gk*8 +: 8]) | SEL_ONES[gk*8 +: 8];
					end
					if (wr_ena[gk]) begin
						en_r[gk*8 +: 8] <= wr_data & IRQ_MASK[gk*8 +: 8];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			ctrl_r <= `UFIF_CTRL_RST;
		end else if (wr_ct) begin
			ctrl_r <= wr_data & `UFIF_CTRL_MASK;
		end
	end

	// Edge history; after reset an attached cable shows as a connection change
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			vbus_prev_r <= 1'b0;
			susp_prev_r <= 1'b0;
		end else begin
			vbus_prev_r <= VBUS;
			susp_prev_r <= BUS_SUSPENDED;
		end
	end

	// Requests: a set flag with its enable, cable level and suspend state excluded by mask
	wire [23:0] irq_req = flags_r & en_r & IRQ_MASK;
	wire vec_a_nxt = |(irq_req & ~sel_r);
	wire vec_b_nxt = |(irq_req & sel_r);
	wire resume_nxt = irq_req[16 + `UFIF_B_SUSP_CHANGE];

	// All top outputs come from flops, so vectors trail the flag by one cycle
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			vec_a_r <= 1'b0;
			vec_b_r <= 1'b0;
			resume_r <= 1'b0;
			ctrl_nack_r <= 1'b1;
			bulk_nack_r <= 1'b1;
			intr_nack_r <= 1'b1;
			self_r <= 1'b0;
			pullup_r <= 1'b0;
		end else begin
			vec_a_r <= vec_a_nxt;
			vec_b_r <= vec_b_nxt;
			resume_r <= resume_nxt;
			ctrl_nack_r <= ~CTRL_IN_TX_VALID;
			bulk_nack_r <= ~BULK_IN_TX_VALID;
			intr_nack_r <= ~INTR_IN_TX_VALID;
			self_r <= ctrl_r[`UFIF_B_POWER_SELF];
			pullup_r <= ctrl_r[`UFIF_B_PULLUP_EN];
		end
	end

	// Operation starts only once endpoint information has been loaded; held until reset
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			run_r <= 1'b0;
		end else if (EPINFO_LOAD_END) begin
			run_r <= 1'b1;
		end
	end

	assign USB_VECTOR_A = vec_a_r;
	assign USB_VECTOR_B = vec_b_r;
	assign RESUME_OUT = resume_r;
	assign CTRL_IN_NACK = ctrl_nack_r;
	assign BULK_IN_NACK = bulk_nack_r;
	assign INTR_IN_NACK = intr_nack_r;
	assign USB_RUN = run_r;
	assign SELF_POWERED = self_r;
	assign PULLUP_ON = pullup_r;

	// Read mux; reads have no side effects, unmapped words read zero
	assign rd_data = rd_f0 ? flags_r[7:0] :
		rd_f1 ? flags_r[15:8] :
		rd_f2 ? flags_r[23:16] :
		rd_s0 ? sel_r[7:0] :
		rd_s1 ? sel_r[15:8] :
		rd_s2 ? sel_r[23:16] :
		rd_e0 ? en_r[7:0] :
		rd_e1 ? en_r[15:8] :
		rd_e2 ? en_r[23:16] :
		rd_ct ? ctrl_r : 8'h00;
endmodule : ufif_top
`default_nettype wire

// file: verification/ufif_host_model.sv
// Behavioural protocol engine and host driving the event and level pins
`timescale 1ns/1ps
`default_nettype none
module ufif_host_model (
	// Clock
	input wire logic MCLK,
	// Requests from the bench
	input wire logic [11:0] ev_req,
	input wire logic [6:0] lv_req,
	// Handshake state from the block
	input wire logic CTRL_IN_NACK,
	input wire logic INTR_IN_NACK,
	// Event pulses and levels towards the block
	output logic [11:0] ev,
	output logic [6:0] lv
);
	initial begin
		ev = 12'h000;
		lv = 7'h00;
	end
	// A token becomes an acknowledged data packet only when the block does not refuse it
	always @(posedge MCLK) begin
		ev <= ev_req | {3'h0, ev[7] & !INTR_IN_NACK, 3'h0, ev[3] & !CTRL_IN_NACK, 4'h0};
		lv <= lv_req;
	end
endmodule : ufif_host_model
`default_nettype wire

// file: verification/ufif_monitor.sv
// Port-level assertions of the USB event flag block
`timescale 1ns/1ps
`default_nettype none
`include "ufif_defs.svh"
module ufif_monitor (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_B,
	// Register bus
	input wire logic [`UFIF_ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic [`UFIF_ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [`UFIF_DATA_W-1:0] RDATA,
	input wire logic RVALID,
	// Endpoint levels, events and outputs
	input wire logic CTRL_IN_TX_VALID,
	input wire logic BULK_IN_TX_VALID,
	input wire logic EPINFO_LOAD_END,
	input wire logic CTRL_IN_NACK,
	input wire logic BULK_IN_NACK,
	input wire logic USB_RUN,
	input wire logic USB_VECTOR_A,
	input wire logic USB_VECTOR_B,
	input wire logic SELF_POWERED,
	input wire logic PULLUP_ON
);
	logic [`UFIF_ADDR_W-1:0] wr_a_r;
	logic [`UFIF_ADDR_W-1:0] rd_a_r;
	logic wr_seen_r;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			wr_a_r <= '0;
			rd_a_r <= '0;
			wr_seen_r <= 1'b0;
		end else begin
			if (AWVALID && AWREADY) wr_a_r <= AWADDR;
			if (ARVALID && ARREADY) rd_a_r <= ARADDR;
			if (WVALID && WREADY) wr_seen_r <= 1'b1;
		end
	end
	AST_CTRL_NACK: assert property ($past(RST_B) |-> CTRL_IN_NACK == !$past(CTRL_IN_TX_VALID))
		else $error("control-in refusal does not follow transmit data");
	AST_BULK_NACK: assert property ($past(RST_B) |-> BULK_IN_NACK == !$past(BULK_IN_TX_VALID))
		else $error("bulk-in refusal does not follow transmit data");
	AST_RUN_CAUSE: assert property ($rose(USB_RUN) |-> $past(EPINFO_LOAD_END))
		else $error("run started without load end");
	AST_RUN_SET: assert property (EPINFO_LOAD_END |=> USB_RUN)
		else $error("run missing after load end");
	AST_RUN_HOLD: assert property (USB_RUN |=> USB_RUN)
		else $error("run dropped without reset");
	AST_VEC_IDLE: assert property (!wr_seen_r |-> !USB_VECTOR_A && !USB_VECTOR_B)
		else $error("vector raised with all enables at reset");
	AST_SELF_PWR: assert property ($changed(SELF_POWERED) |-> $past(BVALID) && wr_a_r == `UFIF_OFS_CONTROL)
		else $error("power mode changed without control write");
	AST_RSV_ZERO: assert property ($rose(RVALID) |-> RDATA[31:8] == 24'h0
		&& (rd_a_r != `UFIF_OFS_FLAGS_1 || RDATA[7:4] == 4'h0)
		&& (rd_a_r != `UFIF_OFS_FLAGS_2 || (RDATA[7:6] == 2'h0 && !RDATA[2])))
		else $error("reserved read data not zero");
	AST_CABLE_GATE: assert property ($rose(RVALID) && rd_a_r == `UFIF_OFS_FLAGS_1 && !PULLUP_ON
		&& !$past(PULLUP_ON) && !$past(PULLUP_ON, 2) |-> !RDATA[3])
		else $error("cable level shown with pull-up off");
	COV_VEC_A: cover property ($rose(USB_VECTOR_A));
	COV_VEC_B: cover property ($rose(USB_VECTOR_B));
	COV_RUN: cover property ($rose(USB_RUN));
endmodule : ufif_monitor
bind ufif_top ufif_monitor u_ufif_monitor (.MCLK(MCLK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID),
	.AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARADDR(ARADDR), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .CTRL_IN_TX_VALID(CTRL_IN_TX_VALID),
	.BULK_IN_TX_VALID(BULK_IN_TX_VALID), .EPINFO_LOAD_END(EPINFO_LOAD_END), .CTRL_IN_NACK(CTRL_IN_NACK),
	.BULK_IN_NACK(BULK_IN_NACK), .USB_RUN(USB_RUN), .USB_VECTOR_A(USB_VECTOR_A), .USB_VECTOR_B(USB_VECTOR_B),
	.SELF_POWERED(SELF_POWERED), .PULLUP_ON(PULLUP_ON));
`default_nettype wire

// file: verification/ufif_top_test.sv
// Self-checking bench of the USB event flag block
`timescale 1ns/1ps
`default_nettype none
`include "ufif_defs.svh"
module ufif_top_test;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic [11:0] ev_req = 12'h000;
	logic [6:0] lv_req = 7'h08;
	logic [11:0] ev;
	logic [6:0] lv;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic [1:0] bresp;
	logic [2:0] nack;
	logic awready, wready, bvalid, arready, rvalid, vec_a, vec_b, resume, run, self_p, pull_on;
	int num_errors = 0;
	int cmp_count = 0;
	ufif_pkg::ufif_flags_t exp_f = 24'h0;
	logic [6:0] lvo = 7'h08;
	logic pu = 1'b0;
	logic ran = 1'b0;
	logic [7:0] ra [5] = '{`UFIF_OFS_SELECT_1, `UFIF_OFS_SELECT_2, `UFIF_OFS_ENABLE_0, `UFIF_OFS_CONTROL, 8'h28};
	logic [7:0] rv [5] = '{8'h07, 8'h1f, 8'h00, 8'h00, 8'h00};
	logic [7:0] vm [3] = '{8'hff, 8'h0f, 8'h3b};
	always #4 mclk = ~mclk;
	ufif_top u_ufif_top (.MCLK(mclk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'h1), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(1'b1),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(1'b1), .BUS_RESET_DET(ev[0]), .SETUP_ACK_DONE(ev[1]), .CTRL_OUT_ACK_DONE(ev[2]),
		.CTRL_IN_TOKEN(ev[3]), .CTRL_IN_ACK_DONE(ev[4]), .BULK_OUT_RX_DONE(ev[5]), .BULK_IN_TOKEN(ev[6]),
		.INTR_IN_TOKEN(ev[7]), .INTR_IN_ACK_DONE(ev[8]), .EPINFO_LOAD_END(ev[9]), .SET_CONFIG_SEEN(ev[10]),
		.SET_ALT_SEEN(ev[11]), .CTRL_IN_TX_VALID(lv[0]), .BULK_OUT_DATA_VALID(lv[1]), .BULK_IN_TX_VALID(lv[2]),
		.BULK_IN_BUF_FREE(lv[3]), .INTR_IN_TX_VALID(lv[4]), .BUS_SUSPENDED(lv[5]), .VBUS(lv[6]),
		.USB_VECTOR_A(vec_a), .USB_VECTOR_B(vec_b), .RESUME_OUT(resume), .CTRL_IN_NACK(nack[0]),
		.BULK_IN_NACK(nack[1]), .INTR_IN_NACK(nack[2]), .USB_RUN(run), .SELF_POWERED(self_p), .PULLUP_ON(pull_on));
	ufif_host_model u_ufif_host_model (.MCLK(mclk), .ev_req(ev_req), .lv_req(lv_req), .CTRL_IN_NACK(nack[0]),
		.INTR_IN_NACK(nack[2]), .ev(ev), .lv(lv));
	function automatic ufif_pkg::ufif_flags_t ev_bits(input int k, input logic [6:0] l);
		case (k)
			0: ev_bits = 24'h000080;
			1: ev_bits = 24'h000008;
			2: ev_bits = 24'h000004;
			3: ev_bits = l[0] ? 24'h000001 : 24'h000002;
			4: ev_bits = 24'h000001;
			6: ev_bits = l[2] ? 24'h000000 : 24'h000020;
			7: ev_bits = l[4] ? 24'h000200 : 24'h000400;
			8: ev_bits = 24'h000200;
			9: ev_bits = 24'h080000;
			10: ev_bits = 24'h020000;
			11: ev_bits = 24'h010000;
			default: ev_bits = 24'h000000;
		endcase
	endfunction : ev_bits
	// Status bits are levels, so they are rebuilt from the pins rather than remembered
	function automatic ufif_pkg::ufif_flags_t stat(input logic [6:0] l, input logic p);
		stat = {2'h0, l[5], 9'h0, l[6] & p, 4'h0, l[1], 1'b0, l[3], 4'h0};
	endfunction : stat
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] dv, input logic [11:0] e);
		@(posedge mclk);
		awaddr <= a;
		wdata <= {24'h0, dv};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		ev_req <= e;
		do begin
			@(posedge mclk);
			ev_req <= 12'h000;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge mclk); while (bvalid !== 1'b1);
		chk("write response", {30'h0, a > `UFIF_OFS_CONTROL ? 2'h2 : 2'h0}, {30'h0, bresp});
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge mclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask : axi_rd
	task automatic chk_flags;
		logic [31:0] d;
		logic [1:0] r;
		ufif_pkg::ufif_flags_t f;
		f = exp_f | stat(lv_req, pu);
		for (int i = 0; i < 3; i++) begin
			axi_rd(8'(4 * i), d, r);
			chk("flags", {24'h0, f[8*i+:8]}, d);
		end
	endtask : chk_flags
	task automatic wrap_up;
		$display("Comparisons %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up
	// The whole sequence needs about a thousand cycles; this bound is some forty times that
	initial begin
		repeat (40000) @(posedge mclk);
		num_errors++;
		wrap_up;
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [6:0] l;
		logic [7:0] m;
		int k;
		int q;
		void'($urandom(77092));
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		chk_flags;
		axi_wr(8'h28, 8'hff, 12'h000);
		foreach (ra[i]) begin
			axi_rd(ra[i], d, r);
			chk("reset value", {22'h0, ra[i] == 8'h28 ? 2'h2 : 2'h0, rv[i]}, {22'h0, r, d[7:0]});
		end
		for (int i = 0; i < 40; i++) begin
			if (i == 20) begin
				axi_wr(`UFIF_OFS_CONTROL, 8'h03, 12'h000);
				pu = 1'b1;
			end
			l = 7'($urandom);
			@(posedge mclk);
			lv_req <= l;
			repeat (3) @(posedge mclk);
			k = $urandom_range(11, 0);
			ran |= (k == 9);
			exp_f |= ev_bits(k, l) | {3'h0, lvo[5] ^ l[5], 11'h0, lvo[6] ^ l[6], 8'h0};
			lvo = l;
			ev_req <= 12'h001 << k;
			@(posedge mclk);
			ev_req <= 12'h000;
			repeat (4) @(posedge mclk);
			chk_flags;
			q = $urandom_range(2, 0);
			m = 8'($urandom) & vm[q];
			axi_wr(8'(4 * q), ~m & vm[q], 12'h000);
			exp_f &= ~(ufif_pkg::ufif_flags_t'(m) << (8 * q));
		end
		axi_wr(`UFIF_OFS_FLAGS_0, 8'h7f, 12'h001);
		exp_f[7] = 1'b1;
		chk_flags;
		axi_wr(`UFIF_OFS_ENABLE_0, 8'h80, 12'h000);
		repeat (4) @(posedge mclk);
		chk("vectors", 32'h2, {30'h0, vec_a, vec_b});
		axi_wr(`UFIF_OFS_SELECT_0, 8'h80, 12'h000);
		repeat (4) @(posedge mclk);
		chk("vectors", 32'h1, {30'h0, vec_a, vec_b});
		axi_wr(`UFIF_OFS_FLAGS_0, 8'h7f, 12'h000);
		exp_f[7] = 1'b0;
		chk_flags;
		chk("vectors", 32'h0, {30'h0, vec_a, vec_b});
		axi_wr(`UFIF_OFS_ENABLE_2, 8'h10, 12'h000);
		l = lvo ^ 7'h20;
		@(posedge mclk);
		lv_req <= l;
		exp_f[20] = 1'b1;
		lvo = l;
		repeat (5) @(posedge mclk);
		chk("resume", 32'h1, {31'h0, resume});
		chk_flags;
		chk("power", 32'h3, {30'h0, self_p, pull_on});
		chk("run", {31'h0, ran}, {31'h0, run});
		chk("refusal", {29'h0, ~lvo[4], ~lvo[2], ~lvo[0]}, {29'h0, nack});
		wrap_up;
	end
endmodule : ufif_top_test
`default_nettype wire
